/* rtl/cfgpin_pkg.sv */
package cfgpin_pkg;

  typedef enum logic [5:0] {
    ST_CLEAR = 6'h01,
    ST_WAIT  = 6'h02,
    ST_LOAD  = 6'h04,
    ST_START = 6'h08,
    ST_USER  = 6'h10,
    ST_READ  = 6'h20
  } cfg_state_t;

  typedef enum logic [1:0] {
    MODE_MASTER = 2'h0,
    MODE_SLAVE  = 2'h1,
    MODE_ASYNC  = 2'h2,
    MODE_HOST   = 2'h3
  } cfg_mode_t;

  // default select-to-mode table, two bits per select value
  localparam logic [31:0] MODE_MAP_DEF = 32'hE4E4E4E4;

  localparam int CLK_NS       = 25;
  localparam int CLEAR_NS     = 1000;
  localparam int CLEAR_CYC    = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HALF_NS = 100;
  localparam int STROBE_HALF  = (STROBE_HALF_NS / CLK_NS > 0) ?
                                STROBE_HALF_NS / CLK_NS : 1;
  localparam int CNT_W        = 16;
  localparam logic [CNT_W-1:0] LOAD_BITS = 16'h0100;
  localparam logic [CNT_W-1:0] RB_BITS   = 16'h0100;
  localparam logic [CNT_W-1:0] CLEAR_LAST =
    CNT_W'(CLEAR_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_LAST  =
    CNT_W'(STROBE_HALF - 1);
  localparam int BYTE_W = 8;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  localparam int SYNC_W = 11;
  localparam int I_RST  = 0;
  localparam int I_PRG  = 1;
  localparam int I_INIT = 2;
  localparam int I_DONE = 3;
  localparam int I_CLK  = 4;
  localparam int I_DIN  = 5;
  localparam int I_RDC  = 6;
  localparam int I_MODE = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h7FF;

  function automatic cfg_mode_t decode_mode(input logic [31:0] map,
                                            input logic [3:0]  sel);
    return cfg_mode_t'(map[{sel, 1'b0} +: 2]);
  endfunction : decode_mode

endpackage : cfgpin_pkg

/* rtl/stream_buffer.sv */
`timescale 1ns/10ps
module stream_buffer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] spare;
  logic             spare_full;
  wire              take = in_valid_i && in_ready_o;
  wire              give = out_valid_o && out_ready_i;

  // head register feeds the output, spare catches a word during a stall
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      spare       <= '0;
      spare_full  <= 1'b0;
    end else begin
      if (!out_valid_o || give) begin
        if (spare_full) begin
          out_data_o  <= spare;
          out_valid_o <= 1'b1;
          spare_full  <= take;
          if (take) spare <= in_data_i;
        end else begin
          out_valid_o <= take;
          if (take) out_data_o <= in_data_i;
        end
      end else if (take) begin
        spare      <= in_data_i;
        spare_full <= 1'b1;
      end
    end
  end

  assign in_ready_o = !spare_full;

endmodule : stream_buffer

/* rtl/fpga_config_pin_control.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module fpga_config_pin_control #(
  parameter logic [31:0] MODE_MAP = cfgpin_pkg::MODE_MAP_DEF
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       reset_pin_n_i,
  input  wire logic       program_restart_n_i,
  input  wire logic       init_in_i,
  output logic            init_out_o,
  output logic            init_oe_o,
  input  wire logic       done_in_i,
  output logic            done_out_o,
  output logic            done_oe_o,
  output logic            done_pullup_o,
  input  wire logic       done_pullup_en_i,
  input  wire logic       config_strobe_clock_in_i,
  output logic            config_strobe_clock_out_o,
  output logic            config_strobe_clock_oe_o,
  input  wire logic       din_i,
  input  wire logic [3:0] mode_sel_i,
  output logic            mode_pullup_o,
  output logic [1:0]      mode_o,
  input  wire logic       rd_cfg_n_i,
  input  wire logic       ts_option_i,
  input  wire logic       readback_en_i,
  input  wire logic       rb_bit_i,
  output logic [15:0]     rb_addr_o,
  input  wire logic       tdo_i,
  output logic            rd_data_o,
  output logic            global_tristate_o,
  input  wire logic       init_fail_i,
  input  wire logic       host_port_en_i,
  input  wire logic       host_irq_i,
  output logic            cfg_irq_n_o,
  input  wire logic       reset_direct_i,
  output logic            user_reset_n_o,
  output logic            user_async_reset_o,
  output logic            bscan_reset_o,
  output logic            high_while_loading_o,
  output logic            low_while_loading_o,
  output logic [7:0]      cfg_data_o,
  output logic            cfg_valid_o,
  input  wire logic       cfg_ready_i
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [cfgpin_pkg::SYNC_W-1:0] s1, s2;
  logic                          clk_prev, init_prev, rdc_prev;
  wire [cfgpin_pkg::SYNC_W-1:0] raw = {mode_sel_i, rd_cfg_n_i, din_i,
    config_strobe_clock_in_i, done_in_i, init_in_i, program_restart_n_i,
    reset_pin_n_i};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1        <= cfgpin_pkg::SYNC_RST;
      s2        <= cfgpin_pkg::SYNC_RST;
      clk_prev  <= 1'b1;
      init_prev <= 1'b1;
      rdc_prev  <= 1'b1;
    end else begin
      s1        <= raw;
      s2        <= s1;
      clk_prev  <= s2[cfgpin_pkg::I_CLK];
      init_prev <= s2[cfgpin_pkg::I_INIT];
      rdc_prev  <= s2[cfgpin_pkg::I_RDC];
    end
  end

  wire clk_rise  = s2[cfgpin_pkg::I_CLK] && !clk_prev;
  wire init_rise = s2[cfgpin_pkg::I_INIT] && !init_prev;
  wire rdc_fall  = !s2[cfgpin_pkg::I_RDC] && rdc_prev;
  wire rdc_low   = !s2[cfgpin_pkg::I_RDC];

  ////////////////////////////////////////////////////////////////////////
  // sequencing
  cfgpin_pkg::cfg_state_t state, next_state;
  cfgpin_pkg::cfg_mode_t  mode;
  logic [cfgpin_pkg::CNT_W-1:0] cnt, div;
  logic                         bit_take, buf_ready;

  wire in_config = state != cfgpin_pkg::ST_USER &&
                   state != cfgpin_pkg::ST_READ;
  wire restart   = !s2[cfgpin_pkg::I_PRG] ||
                   (in_config && !s2[cfgpin_pkg::I_RST]);
  wire drives_clk = mode != cfgpin_pkg::MODE_SLAVE;

  always_comb begin
    next_state = state;
    case (state)
      cfgpin_pkg::ST_CLEAR:
        if (cnt == cfgpin_pkg::CLEAR_LAST) next_state = cfgpin_pkg::ST_WAIT;
      cfgpin_pkg::ST_WAIT:
        if (init_rise) next_state = cfgpin_pkg::ST_LOAD;
      cfgpin_pkg::ST_LOAD:
        if (bit_take && cnt == cfgpin_pkg::LOAD_BITS - 1'b1)
          next_state = cfgpin_pkg::ST_START;
      cfgpin_pkg::ST_START:
        if (s2[cfgpin_pkg::I_DONE]) next_state = cfgpin_pkg::ST_USER;
      cfgpin_pkg::ST_USER:
        if (readback_en_i && !ts_option_i && rdc_fall)
          next_state = cfgpin_pkg::ST_READ;
      cfgpin_pkg::ST_READ:
        if (clk_rise && cnt == cfgpin_pkg::RB_BITS - 1'b1)
          next_state = cfgpin_pkg::ST_USER;
      default: next_state = cfgpin_pkg::ST_CLEAR;
    endcase
    if (restart) next_state = cfgpin_pkg::ST_CLEAR;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) state <= cfgpin_pkg::ST_CLEAR;
    else          state <= next_state;
  end

  // shared counter: clear time, loaded bits, readback bits
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cnt <= '0;
    else if (next_state != state || restart) cnt <= '0;
    else if (state == cfgpin_pkg::ST_CLEAR ||
             (state == cfgpin_pkg::ST_LOAD && bit_take) ||
             (state == cfgpin_pkg::ST_READ && clk_rise))
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) mode <= cfgpin_pkg::MODE_MASTER;
    else if (state == cfgpin_pkg::ST_WAIT && init_rise)
      mode <= cfgpin_pkg::decode_mode(MODE_MAP,
                s2[cfgpin_pkg::I_MODE +: 4]);
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe clock: generated in driving modes, stalled by the buffer
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div                       <= '0;
      config_strobe_clock_out_o <= 1'b0;
    end else if (state != cfgpin_pkg::ST_LOAD || !drives_clk) begin
      div                       <= '0;
      config_strobe_clock_out_o <= 1'b0;
    end else if (div == cfgpin_pkg::HALF_LAST) begin
      div <= '0;
      if (buf_ready || config_strobe_clock_out_o)
        config_strobe_clock_out_o <= !config_strobe_clock_out_o;
    end else begin
      div <= div + 1'b1;
    end
  end

  always_comb begin
    if (drives_clk)
      bit_take = div == cfgpin_pkg::HALF_LAST && buf_ready &&
                 !config_strobe_clock_out_o;
    else
      bit_take = clk_rise;
  end

  // follows state: mode already settled, last rising strobe still driven
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) config_strobe_clock_oe_o <= 1'b0;
    else config_strobe_clock_oe_o <= state == cfgpin_pkg::ST_LOAD &&
                                     drives_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  // serial data into bytes, through the buffer
  logic [7:0] shreg;
  logic       push;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= '0;
      push  <= 1'b0;
    end else begin
      push <= state == cfgpin_pkg::ST_LOAD && bit_take && !restart &&
              cnt[2:0] == cfgpin_pkg::BYTE_LAST;
      if (state == cfgpin_pkg::ST_LOAD && bit_take)
        shreg <= {shreg[6:0], s2[cfgpin_pkg::I_DIN]};
    end
  end

  stream_buffer #(.WIDTH(cfgpin_pkg::BYTE_W)) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (shreg),
    .out_valid_o (cfg_valid_o),
    .out_ready_i (cfg_ready_i),
    .out_data_o  (cfg_data_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // pin outputs
  logic cfg_err;
  wire  next_cfg = next_state != cfgpin_pkg::ST_USER &&
                   next_state != cfgpin_pkg::ST_READ;

  assign init_out_o = 1'b0;
  assign done_out_o = 1'b0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_oe_o            <= 1'b1;
      done_oe_o            <= 1'b1;
      done_pullup_o        <= 1'b0;
      high_while_loading_o <= 1'b1;
      low_while_loading_o  <= 1'b0;
      mode_pullup_o        <= 1'b1;
      mode_o               <= '0;
      bscan_reset_o        <= 1'b1;
      global_tristate_o    <= 1'b1;
      user_reset_n_o       <= 1'b1;
      user_async_reset_o   <= 1'b0;
    end else begin
      init_oe_o            <= next_state == cfgpin_pkg::ST_CLEAR;
      done_oe_o            <= next_cfg &&
                              next_state != cfgpin_pkg::ST_START;
      done_pullup_o        <= done_pullup_en_i;
      high_while_loading_o <= next_cfg;
      low_while_loading_o  <= !next_cfg;
      mode_pullup_o        <= next_cfg;
      mode_o               <= mode;
      bscan_reset_o        <= !s2[cfgpin_pkg::I_PRG];
      global_tristate_o    <= next_cfg ? rdc_low
                              : ts_option_i && rdc_low;
      user_reset_n_o       <= next_cfg || s2[cfgpin_pkg::I_RST];
      user_async_reset_o   <= !next_cfg && reset_direct_i &&
                              !s2[cfgpin_pkg::I_RST];
    end
  end

  // error is sticky until restart; host port reuses the line
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cfg_err <= 1'b0;
    else if (in_config && init_fail_i && !restart) cfg_err <= 1'b1;
    else if (restart) cfg_err <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cfg_irq_n_o <= 1'b1;
    else if (in_config)
      cfg_irq_n_o <= !(cfg_err || (init_fail_i && !restart));
    else
      cfg_irq_n_o <= !(host_port_en_i && host_irq_i);
  end

  // readback from address zero on the shared test data pin
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rb_addr_o <= '0;
      rd_data_o <= 1'b0;
    end else if (state != cfgpin_pkg::ST_READ) begin
      rb_addr_o <= '0;
      rd_data_o <= tdo_i;
    end else if (clk_rise) begin
      rd_data_o <= rb_bit_i;
      rb_addr_o <= rb_addr_o + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_restart;
    restart |=> state == cfgpin_pkg::ST_CLEAR && init_oe_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart did not return to clear");

  property p_init_low;
    state == cfgpin_pkg::ST_CLEAR |-> init_oe_o;
  endproperty
  a_init_low: assert property (p_init_low)
    else $error("init not held low while clearing");

  property p_mode_cap;
    state == cfgpin_pkg::ST_WAIT && init_rise && !restart |=>
      mode == cfgpin_pkg::decode_mode(MODE_MAP,
                $past(s2[cfgpin_pkg::I_MODE +: 4])) ##1 mode_o == mode;
  endproperty
  a_mode_cap: assert property (p_mode_cap)
    else $error("mode not captured on init rise");

  property p_done_wait;
    state == cfgpin_pkg::ST_START && !s2[cfgpin_pkg::I_DONE] && !restart
      |=> state == cfgpin_pkg::ST_START && !done_oe_o;
  endproperty
  a_done_wait: assert property (p_done_wait)
    else $error("start-up went on with done low");

  property p_clk_drive;
    state == cfgpin_pkg::ST_LOAD && drives_clk && !restart
      |=> config_strobe_clock_oe_o || state != cfgpin_pkg::ST_LOAD;
  endproperty
  a_clk_drive: assert property (p_clk_drive)
    else $error("strobe clock not driven in driving mode");

  property p_loading;
    in_config ##1 in_config |-> high_while_loading_o &&
                                !low_while_loading_o;
  endproperty
  a_loading: assert property (p_loading)
    else $error("loading outputs wrong during load");

  property p_tristate;
    in_config && rdc_low && !restart ##1 in_config |-> global_tristate_o;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("tristate not active on readback input low");

  property p_rb_start;
    state == cfgpin_pkg::ST_USER && readback_en_i && !ts_option_i &&
      rdc_fall && !restart
      |=> state == cfgpin_pkg::ST_READ && rb_addr_o == '0;
  endproperty
  a_rb_start: assert property (p_rb_start)
    else $error("readback did not start at address zero");

  property p_err;
    in_config && init_fail_i && !restart |=> !cfg_irq_n_o;
  endproperty
  a_err: assert property (p_err)
    else $error("error line not pulled low");

endmodule : fpga_config_pin_control

/* test/cfg_source_model.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////
module cfg_source_model (
  input  wire logic init_wire_i,
  input  wire logic strobe_wire_i,
  output logic      strobe_clk_o,
  output logic      din_o,
  output logic      done_hold_o,
  output logic      rd_cfg_n_o
);
  logic       follow;
  logic       rd_req_n;
  logic [7:0] acc;
  int         nbit;
  int         seed;
  logic [7:0] exp_q[$];

  initial begin
    follow       = 1'b1;
    rd_req_n     = 1'b1;
    strobe_clk_o = 1'b0;
    din_o        = 1'b0;
    done_hold_o  = 1'b1;
    acc          = 8'h00;
    nbit         = 0;
    seed         = 76;
  end

  // pin kept high until init has risen
  assign rd_cfg_n_o = init_wire_i ? rd_req_n : 1'b1;

  // bytes the device should take, msb first
  always @(posedge strobe_wire_i) begin
    acc  = {acc[6:0], din_o};
    nbit = nbit + 1;
    if (nbit % 8 == 0)
      exp_q.push_back(acc);
  end

  // device-driven strobe: next bit after each fall
  always @(negedge strobe_wire_i)
    if (follow)
      din_o <= #1 1'($random(seed));

  // strobe supplied from here, idle low between frames
  task automatic run_clock(input int n);
    #7;
    repeat (n) begin
      #100 strobe_clk_o = 1'b1;
      #100 strobe_clk_o = 1'b0;
      din_o = 1'($random(seed));
    end
    din_o = ~din_o;
  endtask : run_clock
endmodule : cfg_source_model

/* test/fpga_config_pin_control_bench.sv */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    mismatches++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
  end \
end
`define WAITC(c, n, nm) begin \
  k = 0; \
  while (!(c) && k < n) begin \
    @(posedge clk_sys_i); \
    #1 k++; \
  end \
  `CHK(nm, 1'b1, 1'(c)) \
end
module fpga_config_pin_control_bench;
  logic clk_sys_i, rst_n_i, reset_pin_n_i, program_restart_n_i, init_in_i;
  logic init_out_o, init_oe_o, done_in_i, done_out_o, done_oe_o;
  logic done_pullup_o, done_pullup_en_i, config_strobe_clock_in_i, din_i;
  logic config_strobe_clock_out_o, config_strobe_clock_oe_o, tdo_i;
  logic [3:0] mode_sel_i;
  logic [1:0] mode_o;
  logic [15:0] rb_addr_o;
  logic [7:0] cfg_data_o, exp_b;
  logic mode_pullup_o, rd_cfg_n_i, ts_option_i, readback_en_i, rb_bit_i;
  logic rd_data_o, global_tristate_o, init_fail_i, host_port_en_i;
  logic host_irq_i, cfg_irq_n_o, reset_direct_i, user_reset_n_o;
  logic user_async_reset_o, bscan_reset_o, high_while_loading_o;
  logic low_while_loading_o, cfg_valid_o, cfg_ready_i;
  logic init_hold, done_hold, model_clk, cmp_on, rb_on;
  int   k, got_n, stall, seed, mismatches, checked, rb_n;

  fpga_config_pin_control uut (.clk_sys_i, .rst_n_i, .reset_pin_n_i,
    .program_restart_n_i, .init_in_i, .init_out_o, .init_oe_o, .done_in_i,
    .done_out_o, .done_oe_o, .done_pullup_o, .done_pullup_en_i,
    .config_strobe_clock_in_i, .config_strobe_clock_out_o,
    .config_strobe_clock_oe_o, .din_i, .mode_sel_i, .mode_pullup_o, .mode_o,
    .rd_cfg_n_i, .ts_option_i, .readback_en_i, .rb_bit_i, .rb_addr_o,
    .tdo_i, .rd_data_o, .global_tristate_o, .init_fail_i, .host_port_en_i,
    .host_irq_i, .cfg_irq_n_o, .reset_direct_i, .user_reset_n_o,
    .user_async_reset_o, .bscan_reset_o, .high_while_loading_o,
    .low_while_loading_o, .cfg_data_o, .cfg_valid_o, .cfg_ready_i);

  cfg_source_model model (.init_wire_i(init_in_i),
    .strobe_wire_i(config_strobe_clock_in_i), .strobe_clk_o(model_clk),
    .din_o(din_i), .done_hold_o(done_hold), .rd_cfg_n_o(rd_cfg_n_i));

  // open-drain wires with pull-ups, shared strobe pin
  assign init_in_i = (init_oe_o ? init_out_o : 1'b1) & ~init_hold;
  assign done_in_i = (done_oe_o ? done_out_o : 1'b1) & ~done_hold;
  assign config_strobe_clock_in_i = config_strobe_clock_oe_o ?
                                    config_strobe_clock_out_o : model_clk;
  assign rb_bit_i = rb_addr_o[0] ^ rb_addr_o[2];

  always #12.5 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    if (cfg_valid_o === 1'b1 && cfg_ready_i === 1'b1 && cmp_on) begin
      got_n++;
      exp_b = model.exp_q.size() > 0 ? model.exp_q.pop_front() : 8'hXX;
      `CHK("cfg_data", exp_b, cfg_data_o)
    end
    if (stall > 0)
      stall--;
    cfg_ready_i <= #1 (stall == 0) && ($random(seed) % 2 == 0);
  end

  // each readback strobe rise shows up three clocks later
  always @(posedge model_clk) begin
    if (rb_on) begin
      rb_n++;
      repeat (3) @(posedge clk_sys_i);
      #2;
      `CHK("rd_data", 1'(rb_n - 1) ^ 1'((rb_n - 1) >> 2), rd_data_o)
      `CHK("rb_addr", 16'(rb_n), rb_addr_o)
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic summarize();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic cfg_run(input logic [3:0] sel, input logic full);
    logic [1:0] md;
    md = sel[1:0];
    cmp_on = 1'b0;
    stall = 0;
    program_restart_n_i = 1'b0;
    cyc(4);
    `WAITC(bscan_reset_o === 1'b1, 4, "bscan_reset")
    `CHK("init_oe", 1'b1, init_oe_o)
    init_hold = 1'b1;
    mode_sel_i = sel;
    program_restart_n_i = 1'b1;
    cyc(30);
    `CHK("bscan_reset", 1'b0, bscan_reset_o)
    `CHK("init_oe", 1'b1, init_oe_o)
    `WAITC(init_oe_o === 1'b0, 30, "init_oe")
    `CHK("mode_pullup", 1'b1, mode_pullup_o)
    model.exp_q.delete();
    model.nbit = 0;
    model.follow = (md != 2'h1);
    cmp_on = 1'b1;
    got_n = 0;
    stall = (md != 2'h1) ? 400 : 0;
    init_hold = 1'b0;
    cyc(8);
    mode_sel_i = ~sel;
    `CHK("mode", md, mode_o)
    `CHK("strobe_oe", md != 2'h1, config_strobe_clock_oe_o)
    if (!full) begin
      cyc(300);
      reset_pin_n_i = 1'b0;
      `WAITC(init_oe_o === 1'b1, 6, "init_oe")
      reset_pin_n_i = 1'b1;
      cmp_on = 1'b0;
      return;
    end
    if (md == 2'h1)
      model.run_clock(256);
    if (md == 2'h0) begin
      cyc(600);
      model.rd_req_n = 1'b0;
      cyc(4);
      `CHK("global_tristate", 1'b1, global_tristate_o)
      model.rd_req_n = 1'b1;
    end
    if (md == 2'h2) begin
      cyc(200);
      init_fail_i = 1'b1;
      `WAITC(cfg_irq_n_o === 1'b0, 4, "cfg_irq_n")
      init_fail_i = 1'b0;
    end
    `WAITC(got_n == 32, 6000, "byte_count")
    cyc(40);
    `CHK("high_while_loading", 1'b1, high_while_loading_o)
    `CHK("low_while_loading", 1'b0, low_while_loading_o)
    model.done_hold_o = 1'b0;
    `WAITC(low_while_loading_o === 1'b1, 20, "low_wl")
    `CHK("high_while_loading", 1'b0, high_while_loading_o)
    `CHK("done_oe", 1'b0, done_oe_o)
    `CHK("mode_pullup", 1'b0, mode_pullup_o)
    model.done_hold_o = 1'b1;
  endtask : cfg_run

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clk_sys_i, rst_n_i, init_fail_i, host_port_en_i, host_irq_i} = 5'h00;
    {ts_option_i, readback_en_i, tdo_i, reset_direct_i, cmp_on} = 5'h00;
    {reset_pin_n_i, program_restart_n_i, init_hold} = 3'h7;
    {done_pullup_en_i, cfg_ready_i, rb_on} = 3'h4;
    mode_sel_i = 4'h0;
    {mismatches, checked, stall, got_n, k, rb_n} = '0;
    seed = 76;
    repeat (8) @(posedge clk_sys_i);
    #1;
    `CHK("init_oe", 1'b1, init_oe_o)
    `CHK("high_while_loading", 1'b1, high_while_loading_o)
    `CHK("low_while_loading", 1'b0, low_while_loading_o)
    rst_n_i = 1'b1;
    cfg_run(4'h4, 1'b0);
    cfg_run(4'h4, 1'b1);
    cfg_run(4'h9, 1'b1);
    cfg_run(4'hE, 1'b1);
    cfg_run(4'h3, 1'b1);
    `CHK("done_pullup", 1'b1, done_pullup_o)
    done_pullup_en_i = 1'b0;
    cyc(2);
    `CHK("done_pullup", 1'b0, done_pullup_o)
    `CHK("global_tristate", 1'b0, global_tristate_o)
    host_port_en_i = 1'b1;
    host_irq_i = 1'b1;
    `WAITC(cfg_irq_n_o === 1'b0, 4, "cfg_irq_n")
    host_irq_i = 1'b0;
    `WAITC(cfg_irq_n_o === 1'b1, 4, "cfg_irq_n")
    reset_pin_n_i = 1'b0;
    `WAITC(user_reset_n_o === 1'b0, 5, "user_reset_n")
    `CHK("user_async_reset", 1'b0, user_async_reset_o)
    reset_direct_i = 1'b1;
    `WAITC(user_async_reset_o === 1'b1, 5, "user_async")
    reset_pin_n_i = 1'b1;
    `WAITC(user_reset_n_o === 1'b1, 5, "user_reset_n")
    ts_option_i = 1'b1;
    model.rd_req_n = 1'b0;
    `WAITC(global_tristate_o === 1'b1, 5, "tristate")
    model.rd_req_n = 1'b1;
    `WAITC(global_tristate_o === 1'b0, 5, "tristate")
    tdo_i = 1'b1;
    `WAITC(rd_data_o === 1'b1, 4, "rd_data")
    {ts_option_i, readback_en_i, model.follow} = 3'h2;
    model.rd_req_n = 1'b0;
    cyc(6);
    `CHK("rb_addr", 16'h0000, rb_addr_o)
    rb_on = 1'b1;
    model.run_clock(256);
    cyc(6);
    `CHK("rb_addr", 16'h0000, rb_addr_o)
    `CHK("rd_data", 1'b1, rd_data_o)
    summarize();
  end

  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule : fpga_config_pin_control_bench
